// ### hdl/core_and_peripheral_interrupt_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module core_and_peripheral_interrupt_ctrl (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic emu_irq_i,
   input wire logic reset_irq_i,
   input wire logic pdown_irq_i,
   input wire logic kernel_irq_i,
   input wire logic [31:0] periph_irq_i,
   input wire logic global_irq_on_instr_i,
   input wire logic global_irq_off_instr_i,
   input wire logic irq_ack_i,
   input wire logic irq_return_i,
   input wire logic pc_push_i,
   input wire logic pc_pop_i,
   input wire logic loop_push_i,
   input wire logic loop_pop_i,
   input wire logic creg_wr_i,
   input wire logic [1:0] creg_sel_i,
   input wire logic [15:0] creg_wdata_i,
   output logic [15:0] creg_rdata_o,
   input wire logic io_wr_i,
   input wire logic [2:0] io_addr_i,
   input wire logic [15:0] io_wdata_i,
   output logic [15:0] io_rdata_o,
   output logic emu_req_o,
   output logic irq_req_o,
   output logic [3:0] irq_slot_o,
   output logic [23:0] irq_vector_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [15:0] core_interrupt_mask;
   logic [15:0] core_interrupt_latch;
   logic [1:0] interrupt_control_reg;
   logic [15:0] active;
   logic [15:0] periph_route [intc_pkg::NUM_ROUTE_REGS];
   logic [5:0] pc_level;
   logic [5:0] loop_level;
   logic [5:0] stat_level;
   logic io_written;

   logic ack_fire;
   logic push_any;
   logic pop_any;
   logic [5:0] next_pc_level;
   logic stack_evt;
   logic [11:0] slot_hits;
   logic [15:0] hw_set;
   logic [15:0] ack_clr;
   logic [15:0] eligible;
   logic next_req;
   logic [3:0] next_slot;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [3:0] first_set(input logic [15:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [3:0] route_code(input int src);
      logic [15:0] w;
      w = periph_route[src / intc_pkg::FIELDS_PER_REG];
      return w[(src % intc_pkg::FIELDS_PER_REG) * intc_pkg::ROUTE_W +: intc_pkg::ROUTE_W];
   endfunction

   // Bit i is set when source i is routed to the given user slot.
   function automatic logic [31:0] route_match(input logic [3:0] slot);
      logic [31:0] m;
      m = 32'h0;
      for (int s = 0; s < intc_pkg::NUM_PERIPH; s++) begin
         m[s] = (route_code(s) == slot) && (route_code(s) <= intc_pkg::ROUTE_LAST);
      end
      return m;
   endfunction

   function automatic logic [5:0] bump(input logic [5:0] lvl, input logic up,
                                       input logic dn, input int depth);
      logic [5:0] r;
      r = lvl;
      if (up && !dn && lvl < 6'(depth)) begin
         r = lvl + 6'h01;
      end else if (dn && !up && lvl != 6'h00) begin
         r = lvl - 6'h01;
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // Peripheral mapping
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < intc_pkg::USER_SLOTS; g++) begin : g_map
         assign slot_hits[g] = |(periph_irq_i & route_match(4'(g)));
      end
   endgenerate

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         for (int r = 0; r < intc_pkg::NUM_ROUTE_REGS; r++) begin
            periph_route[r] <= intc_pkg::ROUTE_REG_RST;
         end
      end else if (io_wr_i) begin
         periph_route[io_addr_i] <= io_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         io_written <= 1'b0;
         io_rdata_o <= 16'h0000;
      end else begin
         io_written <= io_written | io_wr_i;
         io_rdata_o <= periph_route[io_addr_i];
      end
   end

   // ---------------------------------------------------------------
   // Stacks
   // ---------------------------------------------------------------
   assign ack_fire = irq_ack_i && irq_req_o;
   assign push_any = ack_fire || pc_push_i;
   assign pop_any = irq_return_i || pc_pop_i;
   assign next_pc_level = bump(pc_level, push_any, pop_any, intc_pkg::PC_DEPTH);
   assign stack_evt = (pc_level >= 6'(intc_pkg::PC_LOW) && next_pc_level < 6'(intc_pkg::PC_LOW))
      || (pc_level <= 6'(intc_pkg::PC_HIGH) && next_pc_level > 6'(intc_pkg::PC_HIGH));

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pc_level <= 6'h00;
         loop_level <= 6'h00;
         stat_level <= 6'h00;
      end else begin
         pc_level <= next_pc_level;
         loop_level <= bump(loop_level, loop_push_i, loop_pop_i, intc_pkg::LOOP_DEPTH);
         stat_level <= bump(stat_level, ack_fire, irq_return_i, intc_pkg::STAT_DEPTH);
      end
   end

   // ---------------------------------------------------------------
   // Latch, mask and control
   // ---------------------------------------------------------------
   always_comb begin
      hw_set = {slot_hits, kernel_irq_i, stack_evt, pdown_irq_i, reset_irq_i};
      ack_clr = ack_fire ? (16'h0001 << irq_slot_o) : 16'h0000;
   end

   // Hardware sets win over any clear in the same cycle.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         core_interrupt_latch <= intc_pkg::LATCH_RST;
      end else if (creg_wr_i && creg_sel_i == intc_pkg::SEL_LATCH) begin
         core_interrupt_latch <= creg_wdata_i | hw_set;
      end else begin
         core_interrupt_latch <= (core_interrupt_latch & ~ack_clr) | hw_set;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         core_interrupt_mask <= intc_pkg::MASK_RST;
      end else if (creg_wr_i && creg_sel_i == intc_pkg::SEL_MASK) begin
         core_interrupt_mask <= creg_wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         interrupt_control_reg <= intc_pkg::CTRL_RST;
      end else begin
         if (creg_wr_i && creg_sel_i == intc_pkg::SEL_CTRL) begin
            interrupt_control_reg <= creg_wdata_i[1:0];
         end
         if (global_irq_on_instr_i) begin
            interrupt_control_reg[intc_pkg::CTRL_GIE] <= 1'b1;
         end else if (global_irq_off_instr_i) begin
            interrupt_control_reg[intc_pkg::CTRL_GIE] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         creg_rdata_o <= 16'h0000;
      end else begin
         unique case (creg_sel_i)
            intc_pkg::SEL_MASK: creg_rdata_o <= core_interrupt_mask;
            intc_pkg::SEL_LATCH: creg_rdata_o <= core_interrupt_latch;
            intc_pkg::SEL_CTRL: creg_rdata_o <= {14'h0000, interrupt_control_reg};
            intc_pkg::SEL_STAT: creg_rdata_o <= {1'b0, stat_level[4:0],
                                                 loop_level[3:0], pc_level};
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Arbitration
   // ---------------------------------------------------------------
   always_comb begin
      eligible = core_interrupt_latch & (core_interrupt_mask | intc_pkg::NONMASK);
      if (!interrupt_control_reg[intc_pkg::CTRL_GIE]) begin
         eligible = eligible & intc_pkg::RESET_ONLY;
      end
      if (active != 16'h0000) begin
         if (interrupt_control_reg[intc_pkg::CTRL_NEST]) begin
            eligible = eligible & ((16'h0001 << first_set(active)) - 16'h0001);
         end else begin
            eligible = eligible & intc_pkg::RESET_ONLY;
         end
      end
      next_req = (eligible != 16'h0000) && !emu_irq_i;
      next_slot = first_set(eligible);
   end

   // A taken request leaves one idle cycle so the cleared latch is seen.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         irq_req_o <= 1'b0;
         irq_slot_o <= 4'h0;
         irq_vector_o <= 24'h000000;
         emu_req_o <= 1'b0;
      end else begin
         irq_req_o <= next_req && !ack_fire;
         irq_slot_o <= next_slot;
         irq_vector_o <= 24'(next_slot) * intc_pkg::VEC_STEP;
         emu_req_o <= emu_irq_i;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         active <= 16'h0000;
      end else begin
         active <= (irq_return_i ? (active & (active - 16'h0001)) : active) | ack_clr;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   sequence s_taken;
      irq_req_o && irq_ack_i;
   endsequence

   sequence s_pc_grow;
      push_any && !pop_any && pc_level < 6'(intc_pkg::PC_DEPTH);
   endsequence

   AST_VECTOR: assert property (irq_req_o |-> irq_vector_o == {15'h0000, irq_slot_o, 5'h00})
      else $error("Vector does not match slot.");

   AST_MASKED: assert property (irq_req_o && irq_slot_o > 4'h1
         |-> (($past(core_interrupt_mask) >> irq_slot_o) & 16'h0001) != 16'h0000)
      else $error("Masked slot was requested.");

   AST_GIE_OFF: assert property (irq_req_o && irq_slot_o != 4'h0
         |-> $past(interrupt_control_reg[intc_pkg::CTRL_GIE]))
      else $error("Slot requested with global servicing off.");

   AST_GIE_ON: assert property ($rose(interrupt_control_reg[intc_pkg::CTRL_GIE])
         |-> $past(global_irq_on_instr_i || (creg_wr_i && creg_sel_i == intc_pkg::SEL_CTRL)))
      else $error("Global enable rose without cause.");

   AST_NEST: assert property (irq_req_o && $past(active) != 16'h0000 && irq_slot_o != 4'h0
         |-> $past(interrupt_control_reg[intc_pkg::CTRL_NEST])
             && irq_slot_o < first_set($past(active)))
      else $error("Preemption violates nesting setting.");

   AST_TAKEN: assert property (s_taken |=> !irq_req_o && active[$past(irq_slot_o)])
      else $error("Taken request not recorded.");

   AST_PC_PUSH: assert property (s_pc_grow |=> pc_level == $past(pc_level) + 6'h01)
      else $error("PC stack did not grow.");

   AST_STACK_LOW: assert property (pc_level == 6'(intc_pkg::PC_LOW) && next_pc_level == 6'h02
         |=> core_interrupt_latch[intc_pkg::SLOT_STACK])
      else $error("Stack-level interrupt missed.");

   AST_ROUTE0: assert property (periph_irq_i[0] && route_code(0) <= intc_pkg::ROUTE_LAST
         |=> core_interrupt_latch[intc_pkg::SLOT_USER0 + $past(route_code(0))])
      else $error("Routed source did not reach its slot.");

   AST_DISCONNECT: assert property (periph_irq_i == 32'h00000001 && route_code(0) > 4'hb
         |-> slot_hits == 12'h000)
      else $error("Disconnected source reached the core.");

   AST_NO_ROUTE: assert property (!io_written |-> slot_hits == 12'h000)
      else $error("Routing active before configuration.");

   AST_HOLD: assert property ($past(core_interrupt_latch[4]) && !$past(ack_fire)
         && !$past(creg_wr_i) |-> core_interrupt_latch[4])
      else $error("User latch bit dropped on its own.");

endmodule
`default_nettype wire

// ### hdl/intc_pkg.sv
// Operation
// - Controller arbitrates exactly seventeen sources, emulator plus sixteen latch slots.
// - Fixed priority, emulator first, then slots 0 to 15; vectors step by 0x20.
// - Pending latch bits are ANDed with mask; highest unmasked request wins.
// - Emulator, power-down, reset ignore mask; power-down still needs global enable.
// - Control register holds nesting and global enable; nesting lets lower-numbered slots preempt.
// - Software latch writes can force or cancel pending requests.
// - Enable and disable instructions switch global servicing regardless of the mask.
// - Global servicing is off after reset until software enables it.
// - Entry pushes and return pops the PC and status stacks; loop stack tracked.
// - Stack-level interrupt fires when PC stack falls below 3 or exceeds 28.
// - Mapper accepts thirty-two peripheral request inputs.
// - Each source owns a 4-bit code, four per 16-bit route register, eight registers.
// - Code n from 0x0 to 0xB routes the source to user slot n.
// - Codes 0xC to 0xF disconnect the source from every core input.
// - Sources sharing a user slot are combined; handler software finds the true source.
// - No peripheral routing is in effect after reset until codes are written.
// - Route registers are reached through the I/O register port.
package intc_pkg;
   localparam int NUM_SLOTS = 16;
   localparam int SLOT_W = 4;
   localparam int VEC_W = 24;
   localparam logic [23:0] VEC_STEP = 24'h000020;
   localparam int SLOT_RESET = 0;
   localparam int SLOT_PDOWN = 1;
   localparam int SLOT_STACK = 2;
   localparam int SLOT_KERNEL = 3;
   localparam int SLOT_USER0 = 4;
   localparam int USER_SLOTS = 12;
   localparam logic [15:0] NONMASK = 16'h0003;
   localparam logic [15:0] RESET_ONLY = 16'h0001;
   localparam int NUM_PERIPH = 32;
   localparam int ROUTE_W = 4;
   localparam logic [3:0] ROUTE_LAST = 4'hb;
   localparam logic [3:0] ROUTE_OFF = 4'hf;
   localparam int FIELDS_PER_REG = 4;
   localparam int NUM_ROUTE_REGS = 8;
   localparam int REG_W = 16;
   localparam logic [15:0] ROUTE_REG_RST = 16'hffff;
   localparam logic [15:0] MASK_RST = 16'h0000;
   localparam logic [15:0] LATCH_RST = 16'h0000;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam int PC_DEPTH = 33;
   localparam int LOOP_DEPTH = 8;
   localparam int STAT_DEPTH = 16;
   localparam int PC_LOW = 3;
   localparam int PC_HIGH = 28;
   localparam logic [1:0] SEL_MASK = 2'h0;
   localparam logic [1:0] SEL_LATCH = 2'h1;
   localparam logic [1:0] SEL_CTRL = 2'h2;
   localparam logic [1:0] SEL_STAT = 2'h3;
   localparam int CTRL_NEST = 0;
   localparam int CTRL_GIE = 1;
   localparam int STAT_PC_LSB = 0;
   localparam int STAT_LOOP_LSB = 6;
   localparam int STAT_STAT_LSB = 10;
endpackage

// ### sim/seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module seq_model (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic irq_req_i,
   input wire logic ack_en_i,
   input wire logic [1:0] ack_wait_i,
   output logic irq_ack_o
);
   // ---------------------------------------------
   // Sequencer acceptance
   // ---------------------------------------------
   logic [1:0] waited;
   // A request is taken after a chosen number of idle cycles, and only while it is shown.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         waited <= 2'h0;
         irq_ack_o <= 1'b0;
      end else begin
         irq_ack_o <= 1'b0;
         if (!irq_req_i || irq_ack_o) begin
            waited <= 2'h0;
         end else if (ack_en_i && waited == ack_wait_i) begin
            irq_ack_o <= 1'b1;
         end else begin
            waited <= waited + 2'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   typedef struct packed {
      logic [4:0] src;
      logic [3:0] code;
      logic hit;
      logic [3:0] slot;
   } row_t;
   logic ref_clk_i = 1'b0, reset_i = 1'b1, emu_irq_i = 1'b0, reset_irq_i = 1'b0;
   logic pdown_irq_i = 1'b0, kernel_irq_i = 1'b0, irq_ack_i, irq_return_i = 1'b0;
   logic global_irq_on_instr_i = 1'b0, global_irq_off_instr_i = 1'b0;
   logic pc_push_i = 1'b0, pc_pop_i = 1'b0, loop_push_i = 1'b0, loop_pop_i = 1'b0;
   logic creg_wr_i = 1'b0, io_wr_i = 1'b0, emu_req_o, irq_req_o, ack_en = 1'b1;
   logic [31:0] periph_irq_i = 32'h0;
   logic [1:0] creg_sel_i = 2'h0, ack_wait = 2'h0;
   logic [2:0] io_addr_i = 3'h0;
   logic [15:0] creg_wdata_i = 16'h0, io_wdata_i = 16'h0, creg_rdata_o, io_rdata_o, v;
   logic [3:0] irq_slot_o;
   logic [23:0] irq_vector_o;
   int err_count = 0, checks = 0;
   row_t rows[16];
   always #2 ref_clk_i = ~ref_clk_i;
   core_and_peripheral_interrupt_ctrl uut (.ref_clk_i, .reset_i, .emu_irq_i, .reset_irq_i,
      .pdown_irq_i, .kernel_irq_i, .periph_irq_i, .global_irq_on_instr_i,
      .global_irq_off_instr_i, .irq_ack_i, .irq_return_i, .pc_push_i, .pc_pop_i, .loop_push_i,
      .loop_pop_i, .creg_wr_i, .creg_sel_i, .creg_wdata_i, .creg_rdata_o, .io_wr_i, .io_addr_i,
      .io_wdata_i, .io_rdata_o, .emu_req_o, .irq_req_o, .irq_slot_o, .irq_vector_o);
   seq_model partner (.ref_clk_i, .reset_i, .irq_req_i(irq_req_o), .ack_en_i(ack_en),
      .ack_wait_i(ack_wait), .irq_ack_o(irq_ack_i));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick();
      s = 1'b0;
      tick();
   endtask
   task automatic cw(input logic [1:0] sel, input logic [15:0] d);
      creg_sel_i = sel;
      creg_wdata_i = d;
      pulse(creg_wr_i);
   endtask
   task automatic cr(input logic [1:0] sel, input logic [15:0] exp);
      creg_sel_i = sel;
      tick();
      check($sformatf("core reg %0d", sel), creg_rdata_o, exp);
   endtask
   task automatic ir(input logic [2:0] a, input logic [15:0] exp);
      io_addr_i = a;
      tick();
      check($sformatf("route reg %0d", a), io_rdata_o, exp);
   endtask
   task automatic wreq(input logic want, input logic [3:0] slot);
      for (int i = 0; i < 8 && irq_req_o !== want; i++) begin
         tick();
      end
      check("request", irq_req_o, want);
      if (irq_req_o !== want) begin
         end_sim();
      end
      if (want) begin
         check("slot", irq_slot_o, slot);
         check("vector", irq_vector_o, {15'h0, slot, 5'h0});
      end
   endtask
   task automatic quiet();
      tick(3);
      check("request", irq_req_o, 1'b0);
   endtask
   initial begin
      for (int r = 0; r < 16; r++) begin
         rows[r] = '{src: (r == 12) ? 5'h00 : 5'(2 * r), code: 4'(r), hit: r < 12,
                     slot: 4'(r + 4)};
      end
      tick(4);
      reset_i = 1'b0;
      // ---------------------------------------------
      // State after reset
      // ---------------------------------------------
      check("request", irq_req_o, 1'b0);
      cr(2'h0, 16'h0000);
      cr(2'h2, 16'h0000);
      cr(2'h3, 16'h0000);
      for (int a = 0; a < 8; a++) begin
         ir(3'(a), 16'hffff);
      end
      periph_irq_i = 32'hffffffff;
      tick(2);
      periph_irq_i = 32'h0;
      cr(2'h1, 16'h0000);
      cw(2'h0, 16'hffff);
      pulse(global_irq_on_instr_i);
      cr(2'h2, 16'h0002);
      // ---------------------------------------------
      // Every routing code n on source 2n, except code 12 on source 0
      // ---------------------------------------------
      foreach (rows[r]) begin
         v = 16'hffff;
         v[rows[r].src[1:0] * 4 +: 4] = rows[r].code;
         io_addr_i = rows[r].src[4:2];
         io_wdata_i = v;
         pulse(io_wr_i);
         ir(rows[r].src[4:2], v);
         ack_wait = rows[r].code[1:0];
         periph_irq_i[rows[r].src] = 1'b1;
         tick();
         periph_irq_i = 32'h0;
         if (rows[r].hit) begin
            wreq(1'b1, rows[r].slot);
            wreq(1'b0, 4'h0);
            pulse(irq_return_i);
         end else begin
            quiet();
            cr(2'h1, 16'h0000);
         end
      end
      // ---------------------------------------------
      // Priority, mask and global enable
      // ---------------------------------------------
      ack_en = 1'b0;
      cw(2'h1, 16'h0220);
      pulse(kernel_irq_i);
      wreq(1'b1, 4'h3);
      cw(2'h0, 16'hfff7);
      wreq(1'b1, 4'h5);
      cw(2'h0, 16'hffd7);
      wreq(1'b1, 4'h9);
      cw(2'h1, 16'h0000);
      quiet();
      cw(2'h0, 16'h0000);
      pulse(pdown_irq_i);
      wreq(1'b1, 4'h1);
      pulse(reset_irq_i);
      wreq(1'b1, 4'h0);
      cw(2'h1, 16'h0000);
      pulse(global_irq_off_instr_i);
      pulse(pdown_irq_i);
      quiet();
      cr(2'h1, 16'h0002);
      cw(2'h0, 16'hffff);
      cw(2'h1, 16'h0010);
      quiet();
      pulse(reset_irq_i);
      wreq(1'b1, 4'h0);
      emu_irq_i = 1'b1;
      tick(2);
      check("emulator", emu_req_o, 1'b1);
      check("request", irq_req_o, 1'b0);
      emu_irq_i = 1'b0;
      cw(2'h1, 16'h0000);
      // ---------------------------------------------
      // Nesting and stacks
      // ---------------------------------------------
      pulse(global_irq_on_instr_i);
      ack_en = 1'b1;
      cw(2'h1, 16'h0200);
      wreq(1'b1, 4'h9);
      wreq(1'b0, 4'h0);
      ack_en = 1'b0;
      cw(2'h1, 16'h0020);
      quiet();
      cw(2'h2, 16'h0003);
      wreq(1'b1, 4'h5);
      ack_en = 1'b1;
      wreq(1'b0, 4'h0);
      pulse(loop_push_i);
      cr(2'h3, 16'h0842);
      pulse(irq_return_i);
      pulse(irq_return_i);
      pulse(loop_pop_i);
      cr(2'h3, 16'h0000);
      cw(2'h0, 16'h0000);
      repeat (3) pulse(pc_push_i);
      cr(2'h1, 16'h0000);
      pulse(pc_pop_i);
      cr(2'h1, 16'h0004);
      cw(2'h1, 16'h0000);
      repeat (26) pulse(pc_push_i);
      cr(2'h1, 16'h0000);
      pulse(pc_push_i);
      cr(2'h1, 16'h0004);
      cr(2'h3, 16'h001d);
      end_sim();
   end
endmodule
`default_nettype wire
